/* bench/pin_b_far.sv */
// Purpose: pin b wire with its pull-up and a far-side push-pull source
// Assumes: far side drives only while the device pin is an input
// Notes:   a pin released by both sides reads high through the pull-up
`timescale 1ns/1ps
`default_nettype none
module pin_b_far
(
   // far side source
   input  wire logic drv_en_in,
   input  wire logic drv_val_in,
   // device side
   input  wire logic dev_oe_in,
   input  wire logic dev_val_in,
   output logic      level_out
);
   // device drive wins; undriven wire floats up, never to a stale value
   assign level_out = dev_oe_in ? dev_val_in : (drv_en_in ? drv_val_in : 1'b1);
endmodule
`default_nettype wire

/* bench/tb.sv */
// Purpose: register-level test of the flash pin mode control
// Assumes: short timeout and deglitch counts set at the instance
// Notes:   pin changes take a few cycles through synchroniser and output flops
`timescale 1ns/1ps
`default_nettype none
module tb;
   import flash_pin_ctrl_pkg::*;
   localparam int TMO = 300;
   logic        clk_in, rst_n_in, wr, rd, stb, pa, trip, uv_low, uv_ok;
   logic        b_en, b_val, b_lvl, b_out, b_oe, ind_on, vout, mon_en;
   logic [7:0]  addr, wdata, rdata;
   logic [3:0]  lvl;
   logic [1:0]  ind_lvl, mon_thr;
   drive_mode_e mode;
   int          n_errors, n_compared;

   flash_pin_ctrl #(.FLASH_TIMEOUT_CYCLES(TMO), .DEGLITCH_CYCLES(20)) dut (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
      .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .strobe_in(stb),
      .pa_sync_input_a_in(pa), .general_io_b_in(b_lvl), .therm_trip_in(trip),
      .input_supply_low_in(uv_low), .input_supply_ok_in(uv_ok),
      .general_io_b_out(b_out), .general_io_b_oe_out(b_oe), .main_source_mode_out(mode),
      .main_source_level_out(lvl), .indicator_driver_on_out(ind_on),
      .indicator_driver_level_out(ind_lvl), .voltage_output_mode_out(vout),
      .monitor_enable_out(mon_en), .monitor_threshold_out(mon_thr));
   pin_b_far far (.drv_en_in(b_en), .drv_val_in(b_val), .dev_oe_in(b_oe),
      .dev_val_in(b_out), .level_out(b_lvl));

   // free-running clock, 4 ns
   initial
   begin
      clk_in = 1'b0;
      forever #2 clk_in = ~clk_in;
   end

   task automatic stop_test();
      $display("compared %0d errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // all drives land 1 ns after a rising edge
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      addr = a;
      wdata = d;
      wr = 1'b1;
      cyc(1);
      wr = 1'b0;
      cyc(1);
   endtask
   // read data is registered at the taking edge
   task automatic rd_reg(input logic [7:0] a);
      addr = a;
      rd = 1'b1;
      cyc(1);
      rd = 1'b0;
      cyc(1);
   endtask
   task automatic wait_mode(input drive_mode_e e, input int n);
      int i;
      i = 0;
      while (mode !== e && i < n)
      begin
         cyc(1);
         i++;
      end
      // a match on the last try is still a match
      if (mode !== e)
      begin
         chk("mode wait", 8'(mode), 8'(e));
         stop_test();
      end
      else
         chk("mode", 8'(mode), 8'(e));
   endtask

   initial
   begin
      {rst_n_in, wr, rd, stb, pa, trip, uv_low, b_val} = '0;
      {uv_ok, b_en} = 2'b11;
      addr = 8'h00;
      wdata = 8'h00;
      n_errors = 0;
      n_compared = 0;
      repeat (16) @(posedge clk_in);
      #1 rst_n_in = 1'b1;
      cyc(1);
      // reset values and an unmapped read
      rd_reg(ADDR_CFG1);
      chk("cfg1", rdata, REG_RESET);
      rd_reg(8'h55);
      chk("unmapped", rdata, 8'h00);
      // register flash, pin a sync, then timeout with pin a still high
      wr_reg(ADDR_FLASH, 8'h03);
      wait_mode(DRV_FLASH, 40);
      pa = 1'b1;
      wait_mode(DRV_TORCH, 40);
      pa = 1'b0;
      wait_mode(DRV_FLASH, 40);
      rd_reg(ADDR_FLAGS);
      chk("flags", rdata, 8'h08);
      rd_reg(ADDR_FLAGS);
      chk("flags", rdata, 8'h00);
      pa = 1'b1;
      wait_mode(DRV_TORCH, 40);
      wait_mode(DRV_OFF, TMO + 40);
      rd_reg(ADDR_FLAGS);
      chk("flags", rdata, 8'h09);
      rd_reg(ADDR_FLASH);
      chk("flash", rdata, 8'h00);
      // hardware torch, overridden by strobe, bit cleared at flash end
      wr_reg(ADDR_CFG1, 8'h80);
      wait_mode(DRV_TORCH, 40);
      stb = 1'b1;
      wait_mode(DRV_FLASH, 40);
      pa = 1'b0;
      stb = 1'b0;
      wait_mode(DRV_OFF, 40);
      rd_reg(ADDR_CFG1);
      chk("cfg1", rdata, 8'h00);
      // pin b: voltage output, active-low torch sync, active-high shutdown
      b_val = 1'b1;
      cyc(8);
      chk("vout", 8'(vout), 8'h01);
      wr_reg(ADDR_CFG1, 8'h20);
      wr_reg(ADDR_FLASH, 8'h03);
      wait_mode(DRV_FLASH, 40);
      b_val = 1'b0;
      wait_mode(DRV_TORCH, 40);
      b_val = 1'b1;
      wait_mode(DRV_FLASH, 40);
      wr_reg(ADDR_CFG2, 8'h01);
      wr_reg(ADDR_CFG1, 8'h60);
      wait_mode(DRV_OFF, 40);
      b_val = 1'b0;
      cyc(8);
      chk("mode", 8'(mode), 8'(DRV_OFF));
      rd_reg(ADDR_FLAGS);
      wait_mode(DRV_FLASH, 40);
      wait_mode(DRV_OFF, TMO + 40);
      // thermistor trip with interrupt output on pin b; far side lets go
      b_en = 1'b0;
      wr_reg(ADDR_CFG2, 8'h00);
      wr_reg(ADDR_GPIO, 8'h58);
      wr_reg(ADDR_CFG1, 8'h08);
      rd_reg(ADDR_FLAGS);
      wr_reg(ADDR_FLASH, 8'h03);
      wait_mode(DRV_FLASH, 40);
      trip = 1'b1;
      cyc(10);
      chk("mode", 8'(mode), 8'(DRV_FLASH));
      wait_mode(DRV_TORCH, 40);
      chk("pin b", 8'({b_oe, b_lvl}), 8'h02);
      rd_reg(ADDR_FLAGS);
      trip = 1'b0;
      cyc(8);
      chk("mode", 8'(mode), 8'(DRV_TORCH));
      chk("pin b", 8'({b_oe, b_lvl}), 8'h01);
      rd_reg(ADDR_FLAGS);
      wait_mode(DRV_FLASH, 40);
      chk("pin b", 8'({b_oe, b_lvl}), 8'h01);
      wait_mode(DRV_OFF, TMO + 40);
      // indicator against thermistor mode
      wr_reg(ADDR_TORCH, 8'hC1);
      cyc(2);
      chk("ind", 8'(ind_on), 8'h00);
      wr_reg(ADDR_CFG1, 8'h00);
      cyc(2);
      chk("ind", 8'({ind_on, ind_lvl}), 8'h07);
      // undervoltage forces off, needs recovery and a flags read
      wr_reg(ADDR_MONITOR, 8'h05);
      wr_reg(ADDR_CFG2, 8'h08);
      wr_reg(ADDR_FLASH, 8'h03);
      chk("mon", 8'({mon_en, mon_thr}), 8'h06);
      wait_mode(DRV_FLASH, 40);
      uv_ok = 1'b0;
      uv_low = 1'b1;
      wait_mode(DRV_OFF, 40);
      uv_low = 1'b0;
      cyc(8);
      chk("mode", 8'(mode), 8'(DRV_OFF));
      uv_ok = 1'b1;
      cyc(4);
      rd_reg(ADDR_FLAGS);
      wait_mode(DRV_FLASH, 40);
      wait_mode(DRV_OFF, TMO + 40);
      // hold mode: pin a before strobe keeps torch past the timeout
      wr_reg(ADDR_CFG2, 8'h04);
      pa = 1'b1;
      cyc(4);
      stb = 1'b1;
      wait_mode(DRV_TORCH, 40);
      cyc(TMO + 20);
      chk("mode", 8'(mode), 8'(DRV_TORCH));
      stb = 1'b0;
      pa = 1'b0;
      wait_mode(DRV_OFF, 40);
      // torch code 1 starts at level 0 and steps once per dwell
      wr_reg(ADDR_TORCH, 8'h0A);
      wait_mode(DRV_TORCH, 40);
      chk("level", 8'(lvl), 8'h00);
      cyc(STEP_CYCLES - 10);
      chk("level", 8'(lvl), 8'h00);
      cyc(20);
      chk("level", 8'(lvl), 8'h01);
      stop_test();
   end
endmodule
`default_nettype wire

/* hdl/flash_pin_ctrl.sv */
// Purpose: mode control of the sync pins, thermistor, monitor and flash drive
// Assumes: analog comparators arrive as logic levels; one clock at 250 MHz
// Notes:   both main sources share one mode and one level code
// Overview of operation
// R01 - configuration-1 bit 7 low makes pin a a sync interrupt input
// R02 - pin a high during flash drops to torch; low again ramps back
// R03 - flash timeout turns main current off whatever pin a does
// R04 - configuration-1 bit 7 high makes pin a a torch enable
// R05 - strobe or register flash overrides the hardware torch enable
// R06 - flash during hardware torch clears configuration-1 bit 7 at flash end
// R07 - configuration-1 bit 5 low makes pin b a voltage-output enable
// R08 - bit 5 high makes pin b a sync input, bit 6 its polarity
// R09 - pin b sync event gives torch or shutdown by configuration-2 bit 0
// R10 - pin b release ramps back; shutdown waits for a flags read
// R11 - general io bit 3 turns pin b into general io
// R12 - interrupt mode drives pin b low when thermal flag sets
// R13 - interrupt output stays low until the flags register is read
// R14 - indicator active with thermistor off and enable field 01
// R15 - configuration-1 bit 3 turns indicator pin into thermistor comparator
// R16 - comparator trip forces torch or shutdown by configuration-2 bit 1
// R17 - thermistor reduction ends after flags read and comparator recovered
// R18 - comparator trip waits a deglitch interval before reducing current
// R19 - hold bit low: pin a torch only during flash until timeout
// R20 - hold bit high: pin a before strobe holds torch without timeout
// R21 - monitor enable, threshold select, torch or off on undervoltage
// R22 - undervoltage reduction ends after recovery and flags read
// R23 - rising current steps through each level at fixed dwell
// R24 - enable field 10 selects torch and 11 flash
// R25 - flags read clears sync flags; later changes recorded anew
// R26 - pin inputs pass a two-stage synchroniser first
`timescale 1ns/1ps
`default_nettype none
module flash_pin_ctrl
   import flash_pin_ctrl_pkg::*;
#(
   parameter int FLASH_TIMEOUT_CYCLES = TIMEOUT_MS * 1000 * CLK_MHZ,
   parameter int DEGLITCH_CYCLES      = DEGLITCH_US * CLK_MHZ
)(
   // clock and reset
   input  wire logic       clk_in,
   input  wire logic       rst_n_in,
   // register port
   input  wire logic [7:0] reg_addr_in,
   input  wire logic [7:0] reg_wdata_in,
   input  wire logic       reg_wr_in,
   input  wire logic       reg_rd_in,
   output logic      [7:0] reg_rdata_out,
   // pins and comparators
   input  wire logic       strobe_in,
   input  wire logic       pa_sync_input_a_in,
   input  wire logic       general_io_b_in,
   input  wire logic       therm_trip_in,
   input  wire logic       input_supply_low_in,
   input  wire logic       input_supply_ok_in,
   // pin b driver
   output logic            general_io_b_out,
   output logic            general_io_b_oe_out,
   // drive controls
   output var drive_mode_e main_source_mode_out,
   output logic      [3:0] main_source_level_out,
   output logic            indicator_driver_on_out,
   output logic      [1:0] indicator_driver_level_out,
   output logic            voltage_output_mode_out,
   output logic            monitor_enable_out,
   output logic      [1:0] monitor_threshold_out
);
   localparam int TW = $clog2(FLASH_TIMEOUT_CYCLES + 1);
   localparam int DW = $clog2(DEGLITCH_CYCLES + 1);
   localparam int SW = $clog2(STEP_CYCLES + 1);
   localparam int NSYNC = 6;

   // elaboration check on counts
   if (FLASH_TIMEOUT_CYCLES < 2 || DEGLITCH_CYCLES < 2)
   begin : g_bad
      $error("counts must be at least two cycles");
   end

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);

   logic [7:0]   monitor_control, torch_reg, flash_reg, cfg1, cfg2, gpio;
   fault_flags_s flags;
   flash_state_e state;
   logic [NSYNC-1:0] sync_a, sync_b;
   logic strobe_s, pin_a_s, pin_b_s, trip_s, uv_s, ok_s;
   logic strobe_d, pin_a_d, b_act_d;
   logic [TW-1:0] timer;
   logic [DW-1:0] ntc_cnt;
   logic [SW-1:0] step_cnt;
   logic by_strobe, b_shdn, ntc_latch, uv_latch;

   // two-stage synchroniser; first stage feeds only the second
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         sync_a <= '0;
         sync_b <= '0;
      end
      else
      begin
         sync_a <= {input_supply_ok_in, input_supply_low_in, therm_trip_in,
                    general_io_b_in, pa_sync_input_a_in, strobe_in}; // R26
         sync_b <= sync_a;                                           // R26
      end
   end
   assign {ok_s, uv_s, trip_s, pin_b_s, pin_a_s, strobe_s} = sync_b;

   // decoded strobes and modes
   logic wr_torch, wr_flash, rd_flags, sync_a_mode, b_gpio, b_sync, b_act;
   logic flash_req, strobe_rise, timer_done, flash_end, start, hold_start;
   logic [1:0] torch_en, flash_en;
   assign wr_torch    = reg_wr_in && reg_addr_in == ADDR_TORCH;
   assign wr_flash    = reg_wr_in && reg_addr_in == ADDR_FLASH;
   assign rd_flags    = reg_rd_in && reg_addr_in == ADDR_FLAGS;
   assign torch_en    = torch_reg[1:0];
   assign flash_en    = flash_reg[1:0];
   assign sync_a_mode = !cfg1[CFG1_HW_TORCH];                        // R01
   assign b_gpio      = gpio[GPIO_B_EN];                             // R11
   assign b_sync      = cfg1[CFG1_B_SYNC] && !b_gpio;                // R08
   assign b_act       = cfg1[CFG1_B_POL] ? pin_b_s : !pin_b_s;       // R08
   assign flash_req   = torch_en == EN_FLASH || flash_en == EN_FLASH; // R24
   assign strobe_rise = strobe_s && !strobe_d;
   assign timer_done  = timer == TW'(FLASH_TIMEOUT_CYCLES - 1);
   // pin a already high at strobe rise in hold mode skips the timeout
   assign hold_start  = strobe_rise && cfg2[CFG2_HOLD] && pin_a_s && sync_a_mode; // R20
   assign start       = state == FL_IDLE && (strobe_rise || flash_req);
   always_comb
   begin
      flash_end = 1'b0;
      unique case (state)
         FL_IDLE:  flash_end = 1'b0;
         FL_FLASH: flash_end = timer_done ||                          // R03
                               (by_strobe && !flash_reg[FLASH_STR] && !strobe_s) ||
                               (!by_strobe && !flash_req);
         FL_HOLD:  flash_end = !strobe_s || !pin_a_s;
      endcase
   end

   // flash sequencing
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         state     <= FL_IDLE;
         by_strobe <= 1'b0;
         timer     <= '0;
      end
      else if (start)
      begin
         state     <= hold_start ? FL_HOLD : FL_FLASH;                // R05
         by_strobe <= strobe_rise;
         timer     <= '0;
      end
      else if (flash_end)
      begin
         state <= FL_IDLE;
         timer <= '0;
      end
      else if (state == FL_FLASH)
      begin
         // strobe retrigger restarts the timeout
         timer <= (strobe_rise && !flash_reg[FLASH_STR]) ? '0 : timer + 1'b1;
      end
   end

   // previous samples for edge detection
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         strobe_d <= 1'b0;
         pin_a_d  <= 1'b0;
         b_act_d  <= 1'b0;
      end
      else
      begin
         strobe_d <= strobe_s;
         pin_a_d  <= pin_a_s;
         b_act_d  <= b_act;
      end
   end

   // brightness registers; flash end from the flash state (not hold) rewrites the enable field to 00
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         torch_reg <= REG_RESET;
         flash_reg <= REG_RESET;
      end
      else
      begin
         if (wr_torch)
            torch_reg <= reg_wdata_in;
         if (wr_flash)
            flash_reg <= reg_wdata_in;
         if (flash_end && state == FL_FLASH)
         begin
            torch_reg[1:0] <= EN_OFF;
            flash_reg[1:0] <= EN_OFF;
         end
      end
   end

   // configuration registers
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         cfg1            <= REG_RESET;
         cfg2            <= REG_RESET;
         gpio            <= REG_RESET;
         monitor_control <= REG_RESET;
      end
      else
      begin
         if (reg_wr_in && reg_addr_in == ADDR_CFG1)
            cfg1 <= reg_wdata_in;
         if (reg_wr_in && reg_addr_in == ADDR_CFG2)
            cfg2 <= reg_wdata_in;
         if (reg_wr_in && reg_addr_in == ADDR_GPIO)
            gpio <= reg_wdata_in;
         if (reg_wr_in && reg_addr_in == ADDR_MONITOR)
            monitor_control <= reg_wdata_in;
         if (flash_end)
            cfg1[CFG1_HW_TORCH] <= 1'b0;                             // R06
      end
   end

   // reduction requests
   logic a_force, b_event, trip_on, off_req, torch_req, ntc_fire;
   assign a_force  = state == FL_FLASH && sync_a_mode && pin_a_s;    // R02 R19
   assign b_event  = b_sync && b_act && state != FL_IDLE;            // R09
   assign trip_on  = cfg1[CFG1_THERM] && trip_s;                     // R15
   assign ntc_fire = trip_on && !ntc_latch &&
                     ntc_cnt == DW'(DEGLITCH_CYCLES - 1);            // R18
   assign off_req  = b_shdn || (ntc_latch && cfg2[CFG2_THERM_SHDN]) || // R16
                     (uv_latch && cfg2[CFG2_UV_OFF]);                // R21
   assign torch_req = a_force || (b_event && !cfg2[CFG2_B_SHDN]) ||  // R09 R10
                      (ntc_latch && !cfg2[CFG2_THERM_SHDN]) ||
                      (uv_latch && !cfg2[CFG2_UV_OFF]);

   // latched reductions; a new cause wins over the flags-read release
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         b_shdn    <= 1'b0;
         ntc_latch <= 1'b0;
         uv_latch  <= 1'b0;
         ntc_cnt   <= '0;
      end
      else
      begin
         if (b_event && cfg2[CFG2_B_SHDN])
            b_shdn <= 1'b1;                                          // R09
         else if (rd_flags && !b_act)
            b_shdn <= 1'b0;                                          // R10
         if (ntc_fire)
            ntc_latch <= 1'b1;                                       // R16
         else if (rd_flags && !trip_on)
            ntc_latch <= 1'b0;                                       // R17
         if (monitor_control[MON_EN] && uv_s)
            uv_latch <= 1'b1;                                        // R21
         else if (rd_flags && ok_s)
            uv_latch <= 1'b0;                                        // R22
         // deglitch window runs while the trip holds and the thermistor latch is clear
         ntc_cnt <= (trip_on && !ntc_latch && !ntc_fire) ? ntc_cnt + 1'b1 : '0; // R18
      end
   end

   // fault flags; a set in the reading cycle survives the clear
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         flags <= '0;
      else
      begin
         flags.timeout <= (state == FL_FLASH && timer_done) ||
                          (flags.timeout && !rd_flags && !start);
         flags.tx1 <= (sync_a_mode && pin_a_s && !pin_a_d) ||
                      (flags.tx1 && !rd_flags);                      // R25
         flags.tx2 <= (b_sync && b_act && !b_act_d) ||
                      (flags.tx2 && !rd_flags);                      // R25
         flags.ntc <= ntc_fire || (flags.ntc && !rd_flags);          // R13
         flags.uv  <= (monitor_control[MON_EN] && uv_s) || (flags.uv && !rd_flags);
      end
   end

   // target drive mode and level
   drive_mode_e target_mode;
   logic [3:0]  target_level;
   always_comb
   begin
      target_mode = DRV_OFF;
      unique case (state)
         FL_FLASH: target_mode = off_req ? DRV_OFF : torch_req ? DRV_TORCH : DRV_FLASH;
         FL_HOLD:  target_mode = off_req ? DRV_OFF : DRV_TORCH;      // R20
         FL_IDLE:  target_mode = off_req ? DRV_OFF :
                                 (torch_en == EN_TORCH || flash_en == EN_TORCH || // R24
                                  (!sync_a_mode && pin_a_s)) ? DRV_TORCH : DRV_OFF; // R04
      endcase
      target_level = (target_mode == DRV_FLASH) ? flash_reg[BR_CODE_LSB +: 4] :
                     {1'b0, torch_reg[BR_CODE_LSB +: 3]};
   end

   // stepped ramp up, immediate drop down
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         main_source_mode_out  <= DRV_OFF;
         main_source_level_out <= '0;
         step_cnt              <= '0;
      end
      else if (target_mode > main_source_mode_out)
      begin
         main_source_mode_out  <= target_mode;
         main_source_level_out <= '0;                                // R23
         step_cnt              <= '0;
      end
      else if (target_mode < main_source_mode_out || target_level < main_source_level_out)
      begin
         main_source_mode_out  <= target_mode;
         main_source_level_out <= (target_mode == DRV_OFF) ? '0 : target_level; // R02
         step_cnt              <= '0;
      end
      else if (target_mode != DRV_OFF && main_source_level_out < target_level)
      begin
         step_cnt <= (step_cnt == SW'(STEP_CYCLES - 1)) ? '0 : step_cnt + 1'b1;
         if (step_cnt == SW'(STEP_CYCLES - 1))
            main_source_level_out <= main_source_level_out + 1'b1;  // R23
      end
      else
         step_cnt <= '0;
   end

   // pin b driver, indicator and mode outputs
   logic int_mode;
   assign int_mode = gpio[GPIO_THERM_INT] && b_gpio && gpio[GPIO_B_DIR] && cfg1[CFG1_THERM];
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         general_io_b_out           <= 1'b0;
         general_io_b_oe_out        <= 1'b0;
         indicator_driver_on_out    <= 1'b0;
         indicator_driver_level_out <= '0;
         voltage_output_mode_out    <= 1'b0;
         monitor_enable_out         <= 1'b0;
         monitor_threshold_out      <= '0;
      end
      else
      begin
         // open-drain interrupt pulls low while the thermal flag stands
         general_io_b_out    <= int_mode ? 1'b0 : gpio[GPIO_B_DATA];  // R12
         general_io_b_oe_out <= int_mode ? flags.ntc :                // R13
                                (b_gpio && gpio[GPIO_B_DIR]);         // R11
         indicator_driver_on_out <= !cfg1[CFG1_THERM] &&              // R14 R15
                                    (torch_en == EN_IND || flash_en == EN_IND);
         indicator_driver_level_out <= torch_reg[IND_LSB +: 2];       // R14
         voltage_output_mode_out <= torch_reg[BR_VOUT] || flash_reg[BR_VOUT] ||
                                    (!cfg1[CFG1_B_SYNC] && !b_gpio && pin_b_s); // R07
         monitor_enable_out    <= monitor_control[MON_EN];            // R21
         monitor_threshold_out <= monitor_control[MON_THR_LSB +: 2];  // R21
      end
   end

   // read data, registered one cycle after the read strobe
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         reg_rdata_out <= '0;
      else if (reg_rd_in)
      begin
         unique case (reg_addr_in)
            ADDR_MONITOR: reg_rdata_out <= monitor_control;
            ADDR_TORCH:   reg_rdata_out <= torch_reg;
            ADDR_FLASH:   reg_rdata_out <= flash_reg;
            ADDR_FLAGS:   reg_rdata_out <= flags;
            ADDR_CFG1:    reg_rdata_out <= cfg1;
            ADDR_CFG2:    reg_rdata_out <= cfg2;
            ADDR_GPIO:    reg_rdata_out <= (b_gpio && !gpio[GPIO_B_DIR]) ?
                                           {gpio[7:6], pin_b_s, gpio[4:0]} : gpio;
            default:      reg_rdata_out <= '0;
         endcase
      end
   end

   sequence s_b_off;
      b_shdn ##1 main_source_mode_out == DRV_OFF;
   endsequence

   sequence s_int_low;
      general_io_b_oe_out && !general_io_b_out;
   endsequence

   a_timeout_ends: assert property ((state == FL_FLASH && timer_done) |=> state == FL_IDLE ##1 main_source_mode_out != DRV_FLASH) else $error("flash outlived timeout"); // R03
   a_hw_torch_on: assert property ((state == FL_IDLE && !sync_a_mode && pin_a_s && !off_req && main_source_mode_out == DRV_OFF) |=> main_source_mode_out == DRV_TORCH) else $error("hardware torch ignored"); // R04
   a_flash_wins: assert property ((state == FL_FLASH && !off_req && !torch_req) |=> main_source_mode_out == DRV_FLASH) else $error("flash not driven"); // R05
   a_torch_clear: assert property (flash_end |=> !cfg1[CFG1_HW_TORCH]) else $error("hardware torch bit kept"); // R06
   a_b_shutdown: assert property ((b_event && cfg2[CFG2_B_SHDN]) |=> s_b_off) else $error("pin b shutdown missed"); // R09
   a_sync_a_torch: assert property ((a_force && !off_req && main_source_mode_out == DRV_FLASH) |=> main_source_mode_out == DRV_TORCH) else $error("pin a did not force torch"); // R02
   a_flags_clear: assert property ((rd_flags && !(sync_a_mode && pin_a_s && !pin_a_d)) |=> !flags.tx1) else $error("sync flag not cleared"); // R25
   a_deglitch_wait: assert property ($rose(ntc_latch) |-> $past(trip_on, 2) && $past(ntc_cnt) == DW'(DEGLITCH_CYCLES - 1)) else $error("thermistor reduced early"); // R18
   a_ramp_single: assert property ((main_source_level_out > $past(main_source_level_out) && $stable(main_source_mode_out)) |-> main_source_level_out == $past(main_source_level_out) + 4'h1) else $error("level jumped upward"); // R23
   a_int_output: assert property ((int_mode && flags.ntc) |=> s_int_low) else $error("interrupt pin not low"); // R12
endmodule
`default_nettype wire

/* inc/flash_pin_ctrl_pkg.sv */
// Purpose: shared constants and types of the flash pin mode control
// Assumes: 8-bit registers on the device register port
// Notes:   brightness enable field sits in bits 1:0 of both brightness registers
package flash_pin_ctrl_pkg;
   // register offsets
   localparam logic [7:0] ADDR_MONITOR = 8'h80;
   localparam logic [7:0] ADDR_TORCH   = 8'hA0;
   localparam logic [7:0] ADDR_FLASH   = 8'hB0;
   localparam logic [7:0] ADDR_FLAGS   = 8'hD0;
   localparam logic [7:0] ADDR_CFG1    = 8'hE0;
   localparam logic [7:0] ADDR_CFG2    = 8'hF0;
   localparam logic [7:0] ADDR_GPIO    = 8'h20;
   localparam logic [7:0] REG_RESET    = 8'h00;
   // primary configuration fields
   localparam int CFG1_HW_TORCH = 7;
   localparam int CFG1_B_POL    = 6;
   localparam int CFG1_B_SYNC   = 5;
   localparam int CFG1_THERM    = 3;
   // secondary configuration fields
   localparam int CFG2_B_SHDN     = 0;
   localparam int CFG2_THERM_SHDN = 1;
   localparam int CFG2_HOLD       = 2;
   localparam int CFG2_UV_OFF     = 3;
   // general io fields
   localparam int GPIO_B_EN      = 3;
   localparam int GPIO_B_DIR     = 4;
   localparam int GPIO_B_DATA    = 5;
   localparam int GPIO_THERM_INT = 6;
   // brightness and monitor fields
   localparam int BR_VOUT      = 2;
   localparam int BR_CODE_LSB  = 3;
   localparam int IND_LSB      = 6;
   localparam int FLASH_STR    = 7;
   localparam int MON_EN       = 0;
   localparam int MON_THR_LSB  = 1;
   localparam logic [1:0] EN_OFF   = 2'h0;
   localparam logic [1:0] EN_IND   = 2'h1;
   localparam logic [1:0] EN_TORCH = 2'h2;
   localparam logic [1:0] EN_FLASH = 2'h3;
   // timing
   localparam int CLK_MHZ     = 250;
   localparam int STEP_US     = 16;
   localparam int STEP_CYCLES = STEP_US * CLK_MHZ;
   localparam int DEGLITCH_US = 250;
   localparam int TIMEOUT_MS  = 32;
   // flash sequencing states
   typedef enum logic [1:0] {FL_IDLE = 2'h0, FL_FLASH = 2'h1, FL_HOLD = 2'h3} flash_state_e;
   // drive modes, ordered by strength
   typedef enum logic [1:0] {DRV_OFF = 2'h0, DRV_TORCH = 2'h1, DRV_FLASH = 2'h3} drive_mode_e;
   // fault flags layout
   typedef struct packed {
      logic spare;
      logic uv;
      logic ntc;
      logic tx2;
      logic tx1;
      logic led_fail;
      logic thermal;
      logic timeout;
   } fault_flags_s;
endpackage
